// ### core/udm_params.svh
`ifndef UDM_PARAMS_SVH
`define UDM_PARAMS_SVH

// Clock rate and pulse widths
`define UDM_CLK_MHZ 250
`define UDM_GO_NS 200
`define UDM_END_NS 100
`define UDM_GO_CYC ((`UDM_GO_NS * `UDM_CLK_MHZ + 999) / 1000)
`define UDM_END_CYC ((`UDM_END_NS * `UDM_CLK_MHZ + 999) / 1000)

// Register selects on host address bits 2:1
`define UDM_SEL_ADDR 2'h0
`define UDM_SEL_COUNT 2'h1
`define UDM_SEL_SLOT4 2'h2
`define UDM_SEL_SLOT6 2'h3

// Control and status register fields
`define UDM_CSR_GO 0
`define UDM_CSR_FN_LO 1
`define UDM_CSR_FN_HI 3
`define UDM_CSR_IE 6
`define UDM_CSR_READY 7
`define UDM_CSR_ST_LO 9
`define UDM_CSR_ST_HI 11
`define UDM_CSR_MAINTENANCE_BIT 12
`define UDM_CSR_PF 14
`define UDM_CSR_ERR 15
`define UDM_CSR_WMASK 16'h104e

// Cycle codes {hi, lo}
`define UDM_READ_WORD 2'h0
`define UDM_READ_PAUSE 2'h1
`define UDM_WRITE_WORD 2'h2
`define UDM_WRITE_BYTE 2'h3

`endif

// ### core/udm_pkg.sv
package udm_pkg;

    typedef enum logic [1:0]
    {
        UDM_IDLE = 2'b00,
        UDM_MEM = 2'b01,
        UDM_END = 2'b11
    } udm_state_e;

    // Inputs from the user device cable
    typedef struct packed
    {
        logic [15:0] data;
        logic code_hi;
        logic code_lo;
        logic cycle_rq;
        logic wc_inc;
        logic ba_inc;
        logic a00;
        logic [2:0] status;
    } udm_user_in_s;

    // Pins from outside the clock domain
    typedef struct packed
    {
        udm_user_in_s user;
        logic power_fail;
        logic bus_init;
        logic [14:0] base_sw;
        logic [2:0] mode_sw;
    } udm_pins_s;

endpackage

// ### core/udm_top.sv
`timescale 1ns/100ps
`include "udm_params.svh"
// Behaviour
// (RULE_01) User data outputs from output data register
// (RULE_02) Init output on power, reset, maintenance clear
// (RULE_03) Function outputs follow control bits 3..1
// (RULE_04) Ready output copies control bit 7
// (RULE_05) Busy high during host cycle, user waits
// (RULE_06) Busy only with mode setting on-off-off
// (RULE_07) Powerfail output on power fail or function b
// (RULE_08) Powerfail mid-transfer: error, inhibit, interrupt
// (RULE_09) Powerfail while idle blocks new transfers
// (RULE_10) Writing go bit gives 200 ns start pulse
// (RULE_11) Cycle end gives 100 ns done pulse
// (RULE_12) Address bits 2:1 pick one of four selects
// (RULE_13) Respond only at switch-set base address
// (RULE_14) Host cycle code chooses read or write
// (RULE_15) Byte writes only to control register
// (RULE_16) User data via input register to host
// (RULE_17) User controls feed control register and logic
// (RULE_18) User cycle code selects memory cycle type
// (RULE_19) Pulse widths counted in clock cycles
module udm_top
    import udm_pkg::*;
#(
    parameter int AW = 18
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [AW-1:0] host_addr_in,
    input wire logic [15:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic host_cycle_code_lo_in,
    input wire logic host_cycle_code_hi_in,
    input wire logic reg_hit_in,
    output logic [15:0] host_rdata_out,
    input wire udm_pins_s pins_in,
    output logic [15:0] output_data_reg_out,
    output logic init_out,
    output logic user_function_bit_c_out,
    output logic user_function_bit_b_out,
    output logic user_function_bit_a_out,
    output logic ready_out,
    output logic busy_out,
    output logic powerfail_function_out,
    output logic start_out,
    output logic cycle_done_out,
    output logic intr_req_out,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic mem_byte_out,
    output logic [AW-1:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [15:0] mem_rdata_in
);

    localparam int PW = $bits(udm_pins_s);
    localparam logic [5:0] GO_CYC = 6'(`UDM_GO_CYC);
    localparam logic [5:0] END_CYC = 6'(`UDM_END_CYC);

    logic [PW-1:0] sync1_r, sync2_r, sync3_r, stable_r;
    udm_pins_s pin;
    logic cycle_rq_d_r, power_fail_d_r;
    logic [AW-1:0] bar_r;
    logic [15:0] wcr_r, csr_r, input_data_reg, output_data_reg;
    logic [2:0] ctrl_reg_r;
    logic ready_r, err_r, inhibit_r, busy_r, intr_r, fin_r;
    logic [5:0] go_cnt_r, end_cnt_r;
    udm_state_e state_r;
    logic [1:0] code_r;
    logic host_sel, wr_word, wr_byte, rd_acc, csr_wr, go_wr, maintenance_bit_clear;
    logic pf_fn, start_dma, mode_ok;
    logic [15:0] byte_mask, csr_nxt;

    // Three-stage synchronisers, value taken when stages two and three agree
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            stable_r <= '0;
        end
        else
        begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < PW; i++)
            begin
                if (sync2_r[i] == sync3_r[i])
                begin
                    stable_r[i] <= sync3_r[i];
                end
            end
        end
    end
    assign pin = udm_pins_s'(stable_r);

    // (RULE_13) Base address match
    assign host_sel = reg_hit_in && (host_addr_in[AW-1:3] == pin.base_sw);
    // (RULE_14) Cycle code picks read or write
    assign wr_word = host_sel && host_wr_in && host_cycle_code_hi_in && !host_cycle_code_lo_in;
    assign wr_byte = host_sel && host_wr_in && host_cycle_code_hi_in && host_cycle_code_lo_in;
    assign rd_acc = host_sel && host_rd_in && !host_cycle_code_hi_in;
    // (RULE_15) Byte writes only reach the control register
    assign csr_wr = (wr_word || wr_byte) && host_addr_in[2:1] == `UDM_SEL_SLOT4;
    assign byte_mask = wr_byte ? (host_addr_in[0] ? 16'hff00 : 16'h00ff) : 16'hffff;
    assign csr_nxt = (csr_r & ~(byte_mask & `UDM_CSR_WMASK))
        | (host_wdata_in & byte_mask & `UDM_CSR_WMASK);
    // (RULE_10) Go bit written as one
    assign go_wr = csr_wr && host_wdata_in[`UDM_CSR_GO] && byte_mask[`UDM_CSR_GO];
    assign maintenance_bit_clear = csr_wr && csr_r[`UDM_CSR_MAINTENANCE_BIT] && !csr_nxt[`UDM_CSR_MAINTENANCE_BIT];
    // (RULE_07) Powerfail or function b
    assign pf_fn = pin.power_fail || csr_r[`UDM_CSR_FN_LO+1];
    // (RULE_06) Mode setting on, off, off
    assign mode_ok = pin.mode_sw == 3'b001;
    // (RULE_09) No start under powerfail, inhibit or while busy
    assign start_dma = state_r == UDM_IDLE && pin.user.cycle_rq && !cycle_rq_d_r
        && !ready_r && !inhibit_r && !err_r && !pf_fn;

    // Host register writes
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            csr_r <= '0;
            output_data_reg <= '0;
        end
        else
        begin
            if (csr_wr)
            begin
                csr_r <= csr_nxt;
            end
            // (RULE_01) Memory read word loads output data
            if (state_r == UDM_MEM && mem_ack_in && code_r == `UDM_READ_WORD)
            begin
                output_data_reg <= mem_rdata_in;
            end
            else if (wr_word && host_addr_in[2:1] == `UDM_SEL_SLOT6)
            begin
                output_data_reg <= host_wdata_in;
            end
        end
    end

    // Address and word count registers
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bar_r <= '0;
            wcr_r <= '0;
        end
        else
        begin
            // (RULE_12) Address select
            if (wr_word && host_addr_in[2:1] == `UDM_SEL_ADDR)
            begin
                bar_r <= AW'({host_wdata_in[AW-3:0], 1'b0});
            end
            else if (state_r == UDM_MEM && mem_ack_in && pin.user.ba_inc)
            begin
                bar_r <= bar_r + AW'(2);
            end
            // (RULE_12) Word count select
            if (wr_word && host_addr_in[2:1] == `UDM_SEL_COUNT)
            begin
                wcr_r <= host_wdata_in;
            end
            else if (state_r == UDM_MEM && mem_ack_in && pin.user.wc_inc)
            begin
                wcr_r <= wcr_r + 16'h0001;
            end
        end
    end

    // (RULE_16) User data into input data register
    // (RULE_17) User controls into input control register
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            input_data_reg <= '0;
            ctrl_reg_r <= '0;
            code_r <= `UDM_READ_WORD;
            cycle_rq_d_r <= 1'b0;
            power_fail_d_r <= 1'b0;
        end
        else
        begin
            cycle_rq_d_r <= pin.user.cycle_rq;
            power_fail_d_r <= pin.power_fail;
            ctrl_reg_r <= pin.user.status;
            if (start_dma)
            begin
                input_data_reg <= pin.user.data;
                code_r <= {pin.user.code_hi, pin.user.code_lo};
            end
        end
    end

    // Memory cycle sequencer
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= UDM_IDLE;
            busy_r <= 1'b0;
            fin_r <= 1'b0;
            mem_req_out <= 1'b0;
            mem_write_out <= 1'b0;
            mem_byte_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= '0;
        end
        else
        begin
            fin_r <= 1'b0;
            case (state_r)
                UDM_IDLE:
                begin
                    if (start_dma)
                    begin
                        // (RULE_05) Busy through the cycle
                        busy_r <= 1'b1;
                        // (RULE_18) Code selects cycle type
                        mem_write_out <= pin.user.code_hi;
                        mem_byte_out <= pin.user.code_hi && pin.user.code_lo;
                        mem_addr_out <= {bar_r[AW-1:1], pin.user.a00};
                        mem_wdata_out <= pin.user.data;
                        mem_req_out <= 1'b1;
                        state_r <= UDM_MEM;
                    end
                end
                UDM_MEM:
                begin
                    if (mem_ack_in)
                    begin
                        mem_req_out <= 1'b0;
                        fin_r <= 1'b1;
                        state_r <= UDM_END;
                    end
                end
                UDM_END:
                begin
                    // (RULE_05) Drop busy at cycle end
                    busy_r <= 1'b0;
                    state_r <= UDM_IDLE;
                end
                default:
                begin
                    state_r <= UDM_IDLE;
                end
            endcase
        end
    end

    // Ready, error and inhibit
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ready_r <= 1'b1;
            err_r <= 1'b0;
            inhibit_r <= 1'b0;
            intr_r <= 1'b0;
        end
        else
        begin
            // (RULE_08) Powerfail during transfer sets error, set wins
            if (state_r != UDM_IDLE && pf_fn)
            begin
                err_r <= 1'b1;
                inhibit_r <= 1'b1;
            end
            else if (go_wr && !pf_fn)
            begin
                err_r <= 1'b0;
                inhibit_r <= 1'b0;
            end
            // (RULE_08) Interrupt after current cycle completes
            if (fin_r && err_r && csr_r[`UDM_CSR_IE])
            begin
                intr_r <= 1'b1;
            end
            else if (go_wr || !csr_r[`UDM_CSR_IE])
            begin
                intr_r <= 1'b0;
            end
            if ((fin_r && (wcr_r == 16'h0000 || err_r)) || (err_r && state_r == UDM_IDLE))
            begin
                ready_r <= 1'b1;
            end
            else if (go_wr && !err_r)
            begin
                ready_r <= 1'b0;
            end
        end
    end

    // (RULE_19) Pulse width counters
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            go_cnt_r <= '0;
            end_cnt_r <= '0;
        end
        else
        begin
            // (RULE_10) Start pulse length
            if (go_wr)
            begin
                go_cnt_r <= GO_CYC;
            end
            else if (go_cnt_r != 6'h00)
            begin
                go_cnt_r <= go_cnt_r - 6'h01;
            end
            // (RULE_11) Done pulse length
            if (fin_r)
            begin
                end_cnt_r <= END_CYC;
            end
            else if (end_cnt_r != 6'h00)
            begin
                end_cnt_r <= end_cnt_r - 6'h01;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            host_rdata_out <= '0;
            output_data_reg_out <= '0;
            init_out <= 1'b1;
            user_function_bit_c_out <= 1'b0;
            user_function_bit_b_out <= 1'b0;
            user_function_bit_a_out <= 1'b0;
            ready_out <= 1'b0;
            busy_out <= 1'b0;
            powerfail_function_out <= 1'b0;
            start_out <= 1'b0;
            cycle_done_out <= 1'b0;
            intr_req_out <= 1'b0;
        end
        else
        begin
            // (RULE_01) Data to user
            output_data_reg_out <= output_data_reg;
            // (RULE_02) Init sources
            init_out <= pin.bus_init || (pin.power_fail != power_fail_d_r) || maintenance_bit_clear;
            // (RULE_03) Function outputs
            user_function_bit_c_out <= csr_r[`UDM_CSR_FN_HI];
            user_function_bit_b_out <= csr_r[`UDM_CSR_FN_LO+1];
            user_function_bit_a_out <= csr_r[`UDM_CSR_FN_LO];
            // (RULE_04) Ready copy
            ready_out <= ready_r;
            // (RULE_06) Busy gated by mode
            busy_out <= busy_r && mode_ok;
            // (RULE_07) Powerfail output
            powerfail_function_out <= pf_fn;
            start_out <= go_wr || go_cnt_r > 6'h01;
            cycle_done_out <= fin_r || end_cnt_r > 6'h01;
            intr_req_out <= intr_r;
            host_rdata_out <= '0;
            if (rd_acc)
            begin
                if (host_addr_in[2:1] == `UDM_SEL_ADDR)
                begin
                    host_rdata_out <= bar_r[15:0];
                end
                else if (host_addr_in[2:1] == `UDM_SEL_COUNT)
                begin
                    host_rdata_out <= wcr_r;
                end
                else if (host_addr_in[2:1] == `UDM_SEL_SLOT4)
                begin
                    host_rdata_out <= {err_r, pf_fn, 1'b0, csr_r[`UDM_CSR_MAINTENANCE_BIT], ctrl_reg_r,
                        1'b0, ready_r, csr_r[`UDM_CSR_IE], 2'b00, csr_r[3:1], 1'b0};
                end
                else
                begin
                    // (RULE_16) Input data to host
                    host_rdata_out <= input_data_reg;
                end
            end
        end
    end

endmodule // udm_top

// ### test/udm_top_props.sv
`timescale 1ns/100ps
`include "udm_params.svh"
module udm_top_props
    import udm_pkg::*;
#(
    parameter int AW = 18
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [AW-1:0] host_addr_in,
    input wire logic [15:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic host_cycle_code_lo_in,
    input wire logic host_cycle_code_hi_in,
    input wire logic reg_hit_in,
    input wire logic [15:0] host_rdata_out,
    input wire udm_pins_s pins_in,
    input wire logic user_function_bit_b_out,
    input wire logic busy_out,
    input wire logic powerfail_function_out,
    input wire logic start_out,
    input wire logic cycle_done_out,
    input wire logic mem_req_out,
    input wire logic mem_ack_in
);
    localparam logic [7:0] GO_N = 8'(`UDM_GO_CYC);
    localparam logic [7:0] END_N = 8'(`UDM_END_CYC);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    logic [7:0] go_n_r;
    logic [7:0] end_n_r;
    logic csr_go;
    logic acked;
    assign csr_go = host_wr_in && reg_hit_in && host_cycle_code_hi_in && !host_cycle_code_lo_in
        && host_addr_in[2:1] == `UDM_SEL_SLOT4 && host_wdata_in[`UDM_CSR_GO]
        && host_addr_in[AW-1:3] == pins_in.base_sw;
    assign acked = mem_req_out && mem_ack_in;
    // Pulse lengths in clock cycles
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            go_n_r <= 8'h0;
            end_n_r <= 8'h0;
        end
        else
        begin
            go_n_r <= start_out ? go_n_r + 8'h1 : 8'h0;
            end_n_r <= cycle_done_out ? end_n_r + 8'h1 : 8'h0;
        end
    end
    property p_go_start;
        csr_go |=> start_out;
    endproperty
    a_go_start: assert property (p_go_start) else $error("no start pulse");
    property p_go_len;
        $fell(start_out) |-> go_n_r == GO_N;
    endproperty
    a_go_len: assert property (p_go_len) else $error("start width");
    property p_done_len;
        $fell(cycle_done_out) |-> end_n_r == END_N;
    endproperty
    a_done_len: assert property (p_done_len) else $error("done width");
    property p_done_ack;
        acked |-> ##2 cycle_done_out;
    endproperty
    a_done_ack: assert property (p_done_ack) else $error("no done pulse");
    property p_busy_drop;
        acked |-> ##3 !busy_out;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy stuck");
    property p_busy_mode;
        busy_out |-> pins_in.mode_sw == 3'h1;
    endproperty
    a_busy_mode: assert property (p_busy_mode) else $error("busy in wrong mode");
    property p_rd_zero;
        !$past(host_rd_in) |-> host_rdata_out == 16'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data stray");
    property p_pf;
        $rose(user_function_bit_b_out) |-> ##[0:1] powerfail_function_out;
    endproperty
    a_pf: assert property (p_pf) else $error("powerfail out low");
    c_go: cover property ($rose(start_out));
    c_done: cover property ($rose(cycle_done_out));
    c_busy: cover property ($rose(busy_out));
endmodule // udm_top_props

// ### test/udm_user_model.sv
`timescale 1ns/100ps
module udm_user_model
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic rq_in,
    input wire logic slow_in,
    input wire logic busy_in,
    input wire logic mem_req_in,
    output logic cycle_rq_out,
    output logic mem_ack_out,
    output logic [15:0] mem_rdata_out
);
    logic [4:0] hold_r;
    logic [4:0] wait_r;
    logic [15:0] word_r;
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
            hold_r <= 5'h0;
        else if (rq_in && !busy_in)
            hold_r <= 5'h8;
        else if (hold_r != 5'h0)
            hold_r <= hold_r - 5'h1;
    assign cycle_rq_out = hold_r != 5'h0;
    // Memory answers after a short or long wait
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
        begin
            wait_r <= 5'h0;
            mem_ack_out <= 1'b0;
            word_r <= 16'h5a3c;
        end
        else
        begin
            mem_ack_out <= mem_req_in && !mem_ack_out && wait_r == (slow_in ? 5'h14 : 5'h1);
            wait_r <= (mem_req_in && !mem_ack_out) ? wait_r + 5'h1 : 5'h0;
            word_r <= mem_ack_out ? {word_r[14:0], word_r[15] ^ word_r[12]} : word_r;
        end
    // Data bus shows the inverse outside the ack cycle
    assign mem_rdata_out = mem_ack_out ? word_r : ~word_r;
endmodule // udm_user_model

// ### test/udm_top_bench.sv
`timescale 1ns/100ps
`include "udm_params.svh"
module udm_top_bench;
    import udm_pkg::*;
    localparam logic [14:0] BASE = 15'h2a31;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [17:0] host_addr_in = 18'h0;
    logic [17:0] mem_addr_out;
    logic [15:0] host_wdata_in = 16'h0;
    logic host_wr_in = 1'b0;
    logic host_rd_in = 1'b0;
    logic host_cycle_code_lo_in = 1'b0;
    logic host_cycle_code_hi_in = 1'b0;
    logic reg_hit_in = 1'b1;
    logic rq = 1'b0;
    logic slow = 1'b0;
    logic crq, mem_ack_in;
    logic [15:0] host_rdata_out, output_data_reg_out, mem_wdata_out, mem_rdata_in, q, v, rdv;
    logic init_out, user_function_bit_c_out, user_function_bit_b_out, user_function_bit_a_out;
    logic ready_out, busy_out, powerfail_function_out, start_out, cycle_done_out;
    logic intr_req_out, mem_req_out, mem_write_out, mem_byte_out;
    logic [14:0] base = BASE;
    udm_pins_s pins;
    udm_pins_s pins_in;
    integer seed = 32'h86af;
    integer err_count = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer n, i, w;
    always #2 ref_clk_in = ~ref_clk_in;
    always_comb
    begin
        pins_in = pins;
        pins_in.user.cycle_rq = crq;
    end
    udm_top i_dut
    (
        .ref_clk_in, .rst_in, .host_addr_in, .host_wdata_in, .host_wr_in, .host_rd_in,
        .host_cycle_code_lo_in, .host_cycle_code_hi_in, .reg_hit_in, .host_rdata_out,
        .pins_in, .output_data_reg_out, .init_out, .user_function_bit_c_out,
        .user_function_bit_b_out, .user_function_bit_a_out, .ready_out, .busy_out,
        .powerfail_function_out, .start_out, .cycle_done_out, .intr_req_out,
        .mem_req_out, .mem_write_out, .mem_byte_out, .mem_addr_out, .mem_wdata_out,
        .mem_ack_in, .mem_rdata_in
    );
    udm_user_model i_user
    (
        .ref_clk_in,
        .rst_in,
        .rq_in(rq),
        .slow_in(slow),
        .busy_in(busy_out),
        .mem_req_in(mem_req_out),
        .cycle_rq_out(crq),
        .mem_ack_out(mem_ack_in),
        .mem_rdata_out(mem_rdata_in)
    );
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask
    task acc(input logic [1:0] c, input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        host_wr_in <= c[1];
        host_rd_in <= !c[1];
        {host_cycle_code_hi_in, host_cycle_code_lo_in} <= c;
        host_addr_in <= {base, a};
        host_wdata_in <= d;
        @(posedge ref_clk_in);
        host_wr_in <= 1'b0;
        host_rd_in <= 1'b0;
        #1 q = host_rdata_out;
    endtask
    function logic sig(input integer k);
        sig = (k == 0) ? init_out : (k == 1) ? mem_req_out : mem_ack_in;
    endfunction
    task wt(input integer k);
        n = 0;
        while (sig(k) !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk_in);
            #1 n++;
        end
    endtask
    task width(input logic s);
        w = 0;
        while ((s ? start_out : cycle_done_out) === 1'b1 && w < 300)
        begin
            @(posedge ref_clk_in);
            #1 w++;
        end
    endtask
    task kick;
        @(posedge ref_clk_in);
        rq <= 1'b1;
        @(posedge ref_clk_in);
        rq <= 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            err_count++;
            wrap_up;
        end
    end
    initial
    begin
        pins = '0;
        pins.base_sw = BASE;
        pins.mode_sw = 3'h1;
        pins.user.status = 3'h5;
        pins.user.data = 16'($random(seed));
        repeat (2) @(posedge ref_clk_in);
        #1 chk1(init_out, 1'b1);
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        #1 chk1(ready_out, 1'b1);
        for (i = 0; i < 6; i++)
        begin
            v = 16'($random(seed)) & 16'h0e4e;
            acc(2'h2, 3'h4, v);
            repeat (2) @(posedge ref_clk_in);
            #1 chk({13'h0, user_function_bit_c_out, user_function_bit_b_out,
                user_function_bit_a_out}, {13'h0, v[3:1]});
            chk1(powerfail_function_out, v[2]);
            acc(2'h0, 3'h4, 16'h0);
            chk(q, (v & `UDM_CSR_WMASK) | 16'h0a80 | {1'b0, v[2], 14'h0});
        end
        acc(2'h2, 3'h4, 16'h1000);
        acc(2'h2, 3'h4, 16'h0000);
        wt(0);
        chk1(init_out, 1'b1);
        reg_hit_in <= 1'b0;
        acc(2'h0, 3'h4, 16'h0);
        chk(q, 16'h0);
        reg_hit_in <= 1'b1;
        base = BASE ^ 15'h1;
        acc(2'h0, 3'h4, 16'h0);
        chk(q, 16'h0);
        base = BASE;
        v = 16'($random(seed));
        acc(2'h2, 3'h0, v);
        acc(2'h0, 3'h0, 16'h0);
        chk(q, v << 1);
        acc(2'h2, 3'h6, v);
        acc(2'h3, 3'h7, ~v);
        acc(2'h0, 3'h6, 16'h0);
        chk(q, 16'h0);
        chk(output_data_reg_out, v);
        acc(2'h2, 3'h2, 16'hfff0);
        acc(2'h2, 3'h4, 16'h0001);
        width(1'b1);
        chk(16'(w), 16'(`UDM_GO_CYC));
        chk1(ready_out, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk_in);
            {pins.user.code_hi, pins.user.code_lo} <= i[1:0];
            pins.user.data <= 16'($random(seed));
            pins.mode_sw <= (i == 1) ? 3'h3 : 3'h1;
            slow <= i[0];
            repeat (6) @(posedge ref_clk_in);
            kick;
            wt(1);
            @(posedge ref_clk_in);
            #1 chk({13'h0, mem_write_out, mem_byte_out, busy_out},
                {13'h0, i[1], i == 3, i != 1});
            chk(mem_addr_out[15:0], v << 1);
            if (i == 2)
                chk(mem_wdata_out, pins.user.data);
            wt(2);
            rdv = mem_rdata_in;
            repeat (2) @(posedge ref_clk_in);
            #1 width(1'b0);
            chk(16'(w), 16'(`UDM_END_CYC));
            chk1(busy_out, 1'b0);
            if (i == 0)
                chk(output_data_reg_out, rdv);
        end
        acc(2'h0, 3'h6, 16'h0);
        chk(q, pins.user.data);
        pins.power_fail <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        #1 chk1(powerfail_function_out, 1'b1);
        kick;
        wt(1);
        chk1(mem_req_out, 1'b0);
        pins.power_fail <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        acc(2'h2, 3'h4, 16'h0041);
        repeat (60) @(posedge ref_clk_in);
        acc(2'h2, 3'h4, 16'h0041);
        kick;
        wt(1);
        pins.power_fail <= 1'b1;
        wt(2);
        repeat (30) @(posedge ref_clk_in);
        #1 chk1(intr_req_out, 1'b1);
        acc(2'h0, 3'h4, 16'h0);
        chk1(q[15], 1'b1);
        wrap_up;
    end
endmodule // udm_top_bench

bind udm_top udm_top_props #(.AW(AW)) u_props
(
    .ref_clk_in, .rst_in, .host_addr_in, .host_wdata_in, .host_wr_in, .host_rd_in,
    .host_cycle_code_lo_in, .host_cycle_code_hi_in, .reg_hit_in, .host_rdata_out,
    .pins_in, .user_function_bit_b_out, .busy_out, .powerfail_function_out,
    .start_out, .cycle_done_out, .mem_req_out, .mem_ack_in
);
